/* File: hw/rtcw_top.sv */
`include "rtcw_consts.svh"
// What this block does
// - Seconds field writable only after selector is 7 and unlock bit set.
// - Field value n from 1 to 63 wakes every n plus one seconds.
// - Field value zero forces a 62.5 ms wakeup interval.
// - Cause flag set with CF flag clear means clock wakeup ended sleep.
// - Cause flag and CF flag both set means a CF pulse woke the system.
// - Correction is 14-bit two's complement split over high and low registers.
// - Seconds one to twenty-nine pulse every 32768 oscillator counts.
// - Thirtieth second pulses at 32768 minus correction plus one.
// - Reading the read unlock register returns zero and enables timing reads.
// - Divider threshold is three byte registers, read and write, reset zero.
// - Divider mode counts zero to threshold, clears, pulses, restarts.
// - Second reference edge stops counter, state 3, count copied to threshold.
// - Selector value 7 means 62.5 ms and permits the seconds extension.
// - Protected writes need key 0x57 first; key 0x56 restores protection.
module rtcw_top
  import rtcw_pkg::*;
#(
  parameter logic [16:0] CAL_SECOND_TICKS = `RTCW_TICKS_SECOND // Oscillator ticks per second.
)
(
  input wire logic core_clk, // Processor clock.
  input wire logic rstn, // Synchronous reset, active low.
  input wire rtcw_sfr_t sfr_req, // Register read and write request.
  output logic [7:0] sfr_rdata, // Read data, valid the cycle after a read.
  input wire logic osc_pin, // 32768 Hz oscillator clock pin.
  input wire logic ref_pin, // Reference one second pulse pin.
  input wire logic pll_tick, // One-cycle enable per divided PLL clock edge.
  input wire logic sleep_mode, // High while the system sleeps.
  input wire logic cf_wake_pulse, // CF pulse wakeup event.
  output logic wake_req, // One-cycle wakeup request.
  output logic cf_pulse_wake_flag, // CF pulse ended the last sleep.
  output logic second_pulse, // Calibrated seconds pulse.
  output logic div_pulse, // Divider mode output pulse.
  output logic timing_read_strobe, // Timing registers may now be read.
  output logic timing_write_enable // Protected registers are writable.
);
  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Seconds per wakeup, zero meaning a sub-second interval.
  function automatic logic [16:0] wake_secs(input logic [2:0] sel, input logic [5:0] n);
    logic [16:0] r;
    r = 17'h00000;
    case (sel)
      3'h0: r = 17'h00001;
      3'h1: r = `RTCW_SECS_MINUTE;
      3'h2: r = `RTCW_SECS_HOUR;
      3'h3: r = `RTCW_SECS_DAY;
      `RTCW_SEL_FAST: r = (n == 6'h00) ? 17'h00000 : {11'h000, n} + 17'h00001;
      default: r = 17'h00000;
    endcase
    return r;
  endfunction
  // Oscillator ticks per sub-second wakeup.
  function automatic logic [14:0] wake_ticks(input logic [2:0] sel);
    logic [14:0] r;
    r = `RTCW_TICKS_62MS5;
    case (sel)
      3'h4: r = `RTCW_TICKS_500MS;
      3'h5: r = `RTCW_TICKS_250MS;
      3'h6: r = `RTCW_TICKS_125MS;
      default: r = `RTCW_TICKS_62MS5;
    endcase
    return r;
  endfunction
  // Terminal count of one calibration second.
  function automatic logic [16:0] cal_term(input logic last, input logic [13:0] c);
    logic [16:0] r;
    r = CAL_SECOND_TICKS;
    if (last) begin
      r = CAL_SECOND_TICKS - {{3{c[13]}}, c} + 17'h00001;
    end
    return r;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] osc_sync, ref_sync;
  logic osc_lvl, ref_lvl, osc_tick, ref_rise;
  logic next_osc_lvl, next_ref_lvl;

  // A level is taken once the second and third stages agree.
  always_comb begin
    next_osc_lvl = (osc_sync[1] == osc_sync[2]) ? osc_sync[2] : osc_lvl;
    next_ref_lvl = (ref_sync[1] == ref_sync[2]) ? ref_sync[2] : ref_lvl;
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      osc_sync <= 3'h0;
      ref_sync <= 3'h0;
      osc_lvl <= 1'b0;
      ref_lvl <= 1'b0;
    end else begin
      osc_sync <= {osc_sync[1:0], osc_pin};
      ref_sync <= {ref_sync[1:0], ref_pin};
      osc_lvl <= next_osc_lvl;
      ref_lvl <= next_ref_lvl;
    end
  end
  assign osc_tick = next_osc_lvl & ~osc_lvl;
  assign ref_rise = next_ref_lvl & ~ref_lvl;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] corr_high, corr_low, sel_reg, sec_reg, pc_upper;
  logic [23:0] div_th;
  logic key_we, cause_flag, cf_flag;
  logic [7:0] next_corr_high, next_corr_low, next_sel_reg, next_sec_reg, next_pc_upper;
  logic [7:0] next_rdata;
  logic [23:0] next_div_th;
  logic next_key_we, next_cause_flag, next_cf_flag, next_rd_strobe;
  logic sleep_d, sw_pc_wr, pc_copy;
  rtcw_pc_t pc_state, next_pc_state;
  logic [23:0] pc_count, next_pc_count;
  logic wake_evt;

  assign sw_pc_wr = sfr_req.wr && sfr_req.addr == `RTCW_A_PC_STATE;

  // Decodes writes and reads and keeps the wakeup cause flags.
  always_comb begin
    next_corr_high = corr_high;
    next_corr_low = corr_low;
    next_sel_reg = sel_reg;
    next_sec_reg = sec_reg;
    next_pc_upper = pc_upper;
    next_div_th = div_th;
    next_key_we = key_we;
    next_cause_flag = cause_flag;
    next_cf_flag = cf_flag;
    next_rd_strobe = 1'b0;
    next_rdata = sfr_rdata;
    if (sfr_req.wr) begin
      case (sfr_req.addr)
        `RTCW_A_KEY: begin
          if (sfr_req.wdata == `RTCW_KEY_OPEN) begin
            next_key_we = 1'b1;
          end else if (sfr_req.wdata == `RTCW_KEY_CLOSE) begin
            next_key_we = 1'b0;
          end
        end
        `RTCW_A_SELECTOR: if (key_we) next_sel_reg = sfr_req.wdata;
        `RTCW_A_CORR_HIGH: if (key_we) next_corr_high = sfr_req.wdata;
        `RTCW_A_CORR_LOW: if (key_we) next_corr_low = sfr_req.wdata;
        `RTCW_A_DIV_HIGH: next_div_th[23:16] = sfr_req.wdata;
        `RTCW_A_DIV_MID: next_div_th[15:8] = sfr_req.wdata;
        `RTCW_A_DIV_LOW: next_div_th[7:0] = sfr_req.wdata;
        `RTCW_A_PC_STATE: next_pc_upper = {sfr_req.wdata[7:2], 2'b00};
        `RTCW_A_SECONDS: begin
          next_sec_reg[7:6] = sfr_req.wdata[7:6];
          if (sel_reg[2:0] == `RTCW_SEL_FAST && sec_reg[`RTCW_SEC_UNLOCK_BIT]) begin
            next_sec_reg[5:0] = sfr_req.wdata[5:0];
          end
        end
        default: begin
        end
      endcase
    end
    // Measured count replaces the threshold, over any software write.
    if (pc_copy) begin
      next_div_th = pc_count;
    end
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        `RTCW_A_CORR_HIGH: next_rdata = corr_high;
        `RTCW_A_CORR_LOW: next_rdata = corr_low;
        `RTCW_A_SELECTOR: next_rdata = sel_reg;
        `RTCW_A_KEY: next_rdata = {7'h00, key_we};
        `RTCW_A_SYS_STATE: next_rdata = {5'h00, cause_flag, 2'b00};
        `RTCW_A_READ_UNLOCK: begin
          next_rdata = 8'h00;
          next_rd_strobe = 1'b1;
        end
        `RTCW_A_DIV_HIGH: next_rdata = div_th[23:16];
        `RTCW_A_DIV_MID: next_rdata = div_th[15:8];
        `RTCW_A_DIV_LOW: next_rdata = div_th[7:0];
        `RTCW_A_PC_STATE: next_rdata = {pc_upper[7:2], pc_state};
        `RTCW_A_SECONDS: next_rdata = sec_reg;
        default: next_rdata = 8'h00;
      endcase
    end
    // Flags clear on sleep entry; a wake event in the same cycle wins.
    if (sleep_mode && !sleep_d) begin
      next_cause_flag = 1'b0;
      next_cf_flag = 1'b0;
    end
    if (sleep_mode && wake_evt) begin
      next_cause_flag = 1'b1;
    end
    if (sleep_mode && cf_wake_pulse) begin
      next_cause_flag = 1'b1;
      next_cf_flag = 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      corr_high <= 8'h00;
      corr_low <= 8'h00;
      sel_reg <= 8'h00;
      sec_reg <= 8'h00;
      pc_upper <= 8'h00;
      div_th <= 24'h000000;
      key_we <= 1'b0;
      cause_flag <= 1'b0;
      cf_flag <= 1'b0;
      sleep_d <= 1'b0;
      sfr_rdata <= 8'h00;
      timing_read_strobe <= 1'b0;
    end else begin
      corr_high <= next_corr_high;
      corr_low <= next_corr_low;
      sel_reg <= next_sel_reg;
      sec_reg <= next_sec_reg;
      pc_upper <= next_pc_upper;
      div_th <= next_div_th;
      key_we <= next_key_we;
      cause_flag <= next_cause_flag;
      cf_flag <= next_cf_flag;
      sleep_d <= sleep_mode;
      sfr_rdata <= next_rdata;
      timing_read_strobe <= next_rd_strobe;
    end
  end
  assign timing_write_enable = key_we;
  assign cf_pulse_wake_flag = cf_flag;

  // ----------------------------------------
  // Calibrated seconds
  // ----------------------------------------
  logic [16:0] cal_cnt, next_cal_cnt;
  logic [4:0] cal_sec, next_cal_sec;
  logic next_second;

  // Counts oscillator ticks; the thirtieth second uses the corrected end.
  always_comb begin
    next_cal_cnt = cal_cnt;
    next_cal_sec = cal_sec;
    next_second = 1'b0;
    if (osc_tick) begin
      if (cal_cnt + 17'h00001 >= cal_term(cal_sec == `RTCW_CAL_LAST_SEC,
                                          {corr_high[5:0], corr_low})) begin
        next_cal_cnt = 17'h00000;
        next_second = 1'b1;
        next_cal_sec = (cal_sec == `RTCW_CAL_LAST_SEC) ? 5'h01 : cal_sec + 5'h01;
      end else begin
        next_cal_cnt = cal_cnt + 17'h00001;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cal_cnt <= 17'h00000;
      cal_sec <= 5'h01;
      second_pulse <= 1'b0;
    end else begin
      cal_cnt <= next_cal_cnt;
      cal_sec <= next_cal_sec;
      second_pulse <= next_second;
    end
  end

  // ----------------------------------------
  // Sleep wakeup timer
  // ----------------------------------------
  logic [14:0] wk_ticks, next_wk_ticks;
  logic [16:0] wk_secs, next_wk_secs, secs_goal;

  assign secs_goal = wake_secs(sel_reg[2:0], sec_reg[5:0]);

  // Counts seconds or raw ticks while asleep and requests a wakeup at the end.
  always_comb begin
    next_wk_ticks = wk_ticks;
    next_wk_secs = wk_secs;
    wake_evt = 1'b0;
    if (!sleep_mode) begin
      next_wk_ticks = 15'h0000;
      next_wk_secs = 17'h00000;
    end else if (secs_goal == 17'h00000) begin
      if (osc_tick) begin
        if (wk_ticks + 15'h0001 >= wake_ticks(sel_reg[2:0])) begin
          next_wk_ticks = 15'h0000;
          wake_evt = 1'b1;
        end else begin
          next_wk_ticks = wk_ticks + 15'h0001;
        end
      end
    end else if (next_second) begin
      if (wk_secs + 17'h00001 >= secs_goal) begin
        next_wk_secs = 17'h00000;
        wake_evt = 1'b1;
      end else begin
        next_wk_secs = wk_secs + 17'h00001;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wk_ticks <= 15'h0000;
      wk_secs <= 17'h00000;
      wake_req <= 1'b0;
    end else begin
      wk_ticks <= next_wk_ticks;
      wk_secs <= next_wk_secs;
      wake_req <= wake_evt;
    end
  end

  // ----------------------------------------
  // Pulse counter
  // ----------------------------------------
  logic next_div_pulse;

  // Divides the PLL ticks or measures the reference second.
  always_comb begin
    next_pc_state = pc_state;
    next_pc_count = pc_count;
    next_div_pulse = 1'b0;
    pc_copy = 1'b0;
    if (sw_pc_wr) begin
      next_pc_state = rtcw_pc_t'(sfr_req.wdata[1:0]);
      if (sfr_req.wdata == `RTCW_PC_ARM) begin
        next_pc_count = 24'h000000;
      end
    end else begin
      case (pc_state)
        PC_DIVIDE: begin
          if (pll_tick) begin
            if (pc_count >= div_th) begin
              next_pc_count = 24'h000000;
              next_div_pulse = 1'b1;
            end else begin
              next_pc_count = pc_count + 24'h000001;
            end
          end
        end
        PC_ARMED: begin
          if (ref_rise) begin
            next_pc_state = PC_RUN;
            next_pc_count = 24'h000000;
          end
        end
        PC_RUN: begin
          if (ref_rise) begin
            next_pc_state = PC_DONE;
            pc_copy = 1'b1;
          end else if (pll_tick) begin
            next_pc_count = pc_count + 24'h000001;
          end
        end
        PC_DONE: next_pc_state = PC_DONE;
        default: next_pc_state = PC_DIVIDE;
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pc_state <= PC_DIVIDE;
      pc_count <= 24'h000000;
      div_pulse <= 1'b0;
    end else begin
      pc_state <= next_pc_state;
      pc_count <= next_pc_count;
      div_pulse <= next_div_pulse;
    end
  end
endmodule

/* File: hw/rtcw_consts.svh */
`ifndef RTCW_CONSTS_SVH
`define RTCW_CONSTS_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define RTCW_A_CORR_HIGH 8'h94
`define RTCW_A_CORR_LOW 8'h95
`define RTCW_A_SELECTOR 8'h96
`define RTCW_A_KEY 8'h97
`define RTCW_A_SYS_STATE 8'ha1
`define RTCW_A_READ_UNLOCK 8'hda
`define RTCW_A_DIV_HIGH 8'hdb
`define RTCW_A_DIV_MID 8'hdc
`define RTCW_A_DIV_LOW 8'hdd
`define RTCW_A_PC_STATE 8'hde
`define RTCW_A_SECONDS 8'hdf
// ----------------------------------------
// Keys, fields and codes
// ----------------------------------------
`define RTCW_KEY_OPEN 8'h57
`define RTCW_KEY_CLOSE 8'h56
`define RTCW_SEL_FAST 3'h7
`define RTCW_SEC_UNLOCK_BIT 6
`define RTCW_CAUSE_BIT 2
`define RTCW_PC_ARM 8'h01
// ----------------------------------------
// Timing counts in oscillator ticks and in seconds
// ----------------------------------------
`define RTCW_TICKS_SECOND 17'h08000
`define RTCW_TICKS_500MS 15'h4000
`define RTCW_TICKS_250MS 15'h2000
`define RTCW_TICKS_125MS 15'h1000
`define RTCW_TICKS_62MS5 15'h0800
`define RTCW_CAL_LAST_SEC 5'h1e
`define RTCW_SECS_MINUTE 17'h0003c
`define RTCW_SECS_HOUR 17'h00e10
`define RTCW_SECS_DAY 17'h15180
`endif

/* File: hw/rtcw_pkg.sv */
package rtcw_pkg;
  // Register access request from the processor core.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtcw_sfr_t;
  // Pulse counter phase, equal to the low two state bits.
  typedef enum logic [1:0] {
    PC_DIVIDE = 2'b00,
    PC_ARMED = 2'b01,
    PC_RUN = 2'b10,
    PC_DONE = 2'b11
  } rtcw_pc_t;
endpackage

/* File: bench/rtcw_chk.sv */
module rtcw_chk
  import rtcw_pkg::*;
(
  input wire logic core_clk, // Clock.
  input wire logic rstn, // Reset.
  input wire rtcw_sfr_t sfr_req, // Request.
  input wire logic [7:0] sfr_rdata, // Read data.
  input wire logic pll_tick, // PLL enable.
  input wire logic sleep_mode, // Asleep.
  input wire logic cf_wake_pulse, // CF event.
  input wire logic wake_req, // Wake pulse.
  input wire logic cf_pulse_wake_flag, // CF flag.
  input wire logic second_pulse, // Seconds.
  input wire logic div_pulse, // Divider out.
  input wire logic timing_read_strobe, // Read strobe.
  input wire logic timing_write_enable // Key open.
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Decode of the read unlock and key accesses.
  wire logic rd_ul = sfr_req.rd && sfr_req.addr == 8'hda;
  wire logic wr_key = sfr_req.wr && sfr_req.addr == 8'h97;
  unlock_read_a: assert property (rd_ul |=> timing_read_strobe && sfr_rdata == 8'h00)
    else $error("read unlock answer wrong");
  strobe_cause_a: assert property (timing_read_strobe |-> $past(rd_ul))
    else $error("stray read strobe");
  key_open_a: assert property (wr_key && sfr_req.wdata == 8'h57 |=> timing_write_enable)
    else $error("key did not open");
  key_close_a: assert property (wr_key && sfr_req.wdata == 8'h56 |=> !timing_write_enable)
    else $error("key did not close");
  key_hold_a: assert property (!wr_key |=> $stable(timing_write_enable))
    else $error("key state moved");
  wake_sleep_a: assert property (wake_req |-> $past(sleep_mode))
    else $error("wake while awake");
  cf_set_a: assert property (sleep_mode && cf_wake_pulse |=> cf_pulse_wake_flag)
    else $error("cf flag not set");
  cf_clear_a: assert property ($rose(sleep_mode) && !cf_wake_pulse |=> !cf_pulse_wake_flag)
    else $error("cf flag not cleared");
  div_cause_a: assert property (div_pulse |-> $past(pll_tick) ##1 !div_pulse)
    else $error("divider pulse wrong");
  sec_width_a: assert property (second_pulse |=> !second_pulse)
    else $error("seconds pulse too long");
endmodule
bind rtcw_top rtcw_chk chk (.core_clk, .rstn, .sfr_req, .sfr_rdata, .pll_tick, .sleep_mode,
  .cf_wake_pulse, .wake_req, .cf_pulse_wake_flag, .second_pulse, .div_pulse,
  .timing_read_strobe, .timing_write_enable);

/* File: bench/rtcw_mcu.sv */
module rtcw_mcu
  import rtcw_pkg::*;
(
  input wire logic core_clk, // Clock.
  output rtcw_sfr_t sfr_req, // Request.
  input wire logic [7:0] sfr_rdata // Read data.
);
  timeunit 1ns;
  timeprecision 100ps;
  // The core starts with no request.
  initial sfr_req = '0;
  // One transfer, launched after an edge, taken at the next; idle lines go inverted.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge core_clk);
    #1 sfr_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge core_clk);
    #1 sfr_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    q = sfr_rdata;
  endtask
endmodule

/* File: bench/rtcw_top_tb.sv */
module rtcw_top_tb
  import rtcw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, rstn = 0, osc_pin = 0, ref_pin = 0, pll_tick = 0;
  logic sleep_mode = 0, cf_wake_pulse = 0, osc_run = 0;
  rtcw_sfr_t sfr_req;
  logic [7:0] sfr_rdata, q;
  logic wake_req, cf_pulse_wake_flag, second_pulse, div_pulse;
  logic timing_read_strobe, timing_write_enable;
  logic [7:0] d[3];
  logic [13:0] cv;
  localparam int SEC = 64;
  int fail_count = 0, compares = 0, n_osc = 0, n_div = 0, n_sec = 0, t, m;
  rtcw_top #(.CAL_SECOND_TICKS(17'(SEC))) uut (.core_clk, .rstn, .sfr_req, .sfr_rdata,
    .osc_pin, .ref_pin, .pll_tick,
    .sleep_mode, .cf_wake_pulse, .wake_req, .cf_pulse_wake_flag, .second_pulse,
    .div_pulse, .timing_read_strobe, .timing_write_enable);
  rtcw_mcu mcu (.core_clk, .sfr_req, .sfr_rdata);
  // Clock, oscillator of four core cycles a tick, and event counters.
  always #4 core_clk = ~core_clk;
  always begin
    repeat (2) @(posedge core_clk);
    #1 osc_pin = osc_run & ~osc_pin;
  end
  // Falling edges are counted, so a sample taken at a pulse never meets a rise.
  always @(negedge osc_pin) n_osc++;
  always @(posedge core_clk) if (div_pulse) n_div++;
  always @(posedge core_clk) if (second_pulse) n_sec++;
  // Ticks in calibration second k since reset; every thirtieth one is corrected.
  function automatic int sec_len(input int k, input logic [13:0] c);
    return (k % 30 == 0) ? SEC - int'($signed(c)) + 1 : SEC;
  endfunction
  // Comparison, verdict and bus helpers.
  task automatic check(input string what, input logic [23:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    mcu.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, exp);
    mcu.xfer(1'b0, a, 8'h00, q);
    check($sformatf("reg %h", a), 24'(q), 24'(exp));
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      pll_tick = 1;
      idle(1);
      pll_tick = 0;
      idle(1);
    end
  endtask
  task automatic wait_wake(input bit sec = 1'b0);
    int i;
    for (i = 0; i < 10000 && (sec ? second_pulse : wake_req) !== 1'b1; i++) idle(1);
    if (i == 10000) begin
      check("wake timeout", 24'h1, 24'h0);
      stop_test();
    end
  endtask
  // ----
  // Tests
  // ----
  initial begin
    void'($urandom(28));
    idle(20);
    rstn = 1;
    foreach (d[i]) rd_chk(8'hdb + 8'(i), 8'h00);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'hda, 8'h00);
    check("read strobe", 24'(timing_read_strobe), 24'h1);
    foreach (d[i]) d[i] = 8'($urandom);
    foreach (d[i]) wr(8'hdb + 8'(i), d[i]);
    foreach (d[i]) rd_chk(8'hdb + 8'(i), d[i]);
    $display("test registers done");
    wr(8'h95, 8'h5a);
    rd_chk(8'h95, 8'h00);
    wr(8'h97, 8'h57);
    check("write enable", 24'(timing_write_enable), 24'h1);
    wr(8'h94, d[0]);
    wr(8'h95, d[1]);
    rd_chk(8'h94, d[0]);
    rd_chk(8'h95, d[1]);
    wr(8'h96, 8'h07);
    rd_chk(8'h96, 8'h07);
    wr(8'h97, 8'h56);
    wr(8'h94, ~d[0]);
    rd_chk(8'h94, d[0]);
    $display("test protection done");
    cv = 14'($urandom_range(16, 0)) - 14'h0008;
    wr(8'h97, 8'h57);
    wr(8'h94, {2'b00, cv[13:8]});
    wr(8'h95, cv[7:0]);
    wr(8'h97, 8'h56);
    wr(8'hdf, 8'h45);
    rd_chk(8'hdf, 8'h40);
    m = $urandom_range(63, 1);
    wr(8'hdf, 8'h40 | 8'(m));
    rd_chk(8'hdf, 8'h40 | 8'(m));
    wr(8'hdf, 8'h40);
    osc_run = 1;
    sleep_mode = 1;
    wait_wake();
    t = n_osc;
    idle(2);
    wait_wake();
    check("wake ticks", 24'(n_osc - t), 24'(32768 / 16));
    mcu.xfer(1'b0, 8'ha1, 8'h00, q);
    check("cause flag", 24'(q[2]), 24'h1);
    check("cf flag", 24'(cf_pulse_wake_flag), 24'h0);
    cf_wake_pulse = 1;
    idle(1);
    cf_wake_pulse = 0;
    check("cf flag", 24'(cf_pulse_wake_flag), 24'h1);
    mcu.xfer(1'b0, 8'ha1, 8'h00, q);
    check("cause flag", 24'(q[2]), 24'h1);
    sleep_mode = 0;
    osc_run = 0;
    idle(1);
    sleep_mode = 1;
    idle(2);
    check("cf flag", 24'(cf_pulse_wake_flag), 24'h0);
    sleep_mode = 0;
    $display("test wakeup done");
    m = $urandom_range(5, 1);
    wr(8'hdb, 8'h00);
    wr(8'hdc, 8'h00);
    wr(8'hdd, 8'(m));
    wr(8'hde, 8'h00);
    n_div = 0;
    ticks(3 * (m + 1));
    idle(2);
    check("div pulses", 24'(n_div), 24'h3);
    wr(8'hde, 8'h01);
    ref_pin = 1;
    idle(8);
    ref_pin = 0;
    idle(8);
    m = $urandom_range(200, 1);
    ticks(m);
    idle(8);
    ref_pin = 1;
    idle(8);
    ref_pin = 0;
    rd_chk(8'hde, 8'h03);
    rd_chk(8'hdd, 8'(m));
    rd_chk(8'hdc, 8'h00);
    $display("test pulse counter done");
    m = $urandom_range(7, 1);
    wr(8'hdf, 8'h40 | 8'(m));
    osc_run = 1;
    sleep_mode = 1;
    wait_wake();
    t = n_sec;
    idle(1);
    wait_wake();
    check("wake seconds", 24'(n_sec - t), 24'(m + 1));
    sleep_mode = 0;
    wait_wake(1'b1);
    for (int k = 0; k < 31; k++) begin
      t = n_osc;
      m = n_sec;
      idle(1);
      wait_wake(1'b1);
      check("second ticks", 24'(n_osc - t), 24'(sec_len(m + 2, cv)));
    end
    $display("test seconds done");
    stop_test();
  end
endmodule
